// File: rtl/smon_result_regs.sv
// signal monitor period, result control and result registers on AXI4-Lite
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Summary of operation
// - update write copies selected measurement into results
// - update bit clears itself after the copy
// - control bit 0 selects peak detector source
// - peak magnitude goes to result bits 19:7
// - result bits 6:0 zero with peak selected
module smon_result_regs
  import smon_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire smon_axi_req_t          axi_req,
  output smon_axi_rsp_t               axi_rsp,
  input  wire logic [SMON_PEAK_W-1:0] peak_abs,
  output logic                        peak_enable,
  output logic [SMON_PER_W-1:0]       monitor_period
);

  smon_state_t q;                         // registered state
  smon_state_t d;                         // next state
  logic [SMON_PCNT_W-1:0] period_count;   // live completed period count
  logic                   commit;         // address and data both held
  logic [SMON_IDX_W-1:0]  rd_idx;         // index of the read request

  // is the index one of ours
  function automatic logic idx_hit(input logic [SMON_IDX_W-1:0] idx);
    idx_hit = (idx >= SMON_IDX_PER_LO) && (idx <= SMON_IDX_PCNT);
  endfunction

  // read value of a register
  function automatic logic [SMON_BYTE_W-1:0] read_byte(
    input logic [SMON_IDX_W-1:0] idx,
    input smon_state_t           s
  );
    logic [SMON_BYTE_W-1:0] v;
    v = '0;
    unique case (idx)
      SMON_IDX_PER_LO:  v = s.period[7:0];
      SMON_IDX_PER_MID: v = s.period[15:8];
      SMON_IDX_PER_HI:  v = s.period[23:16];
      SMON_IDX_CTL: begin
        v[SMON_CTL_PEAK_BIT]   = s.peak_sel;
        v[SMON_CTL_UPDATE_BIT] = s.update;
      end
      SMON_IDX_RES0:    v = s.result[7:0];
      SMON_IDX_RES1:    v = s.result[15:8];
      SMON_IDX_RES2:    v = {4'h0, s.result[19:16]};
      SMON_IDX_PCNT:    v = s.pcount;
      default:          v = '0;
    endcase
    read_byte = v;
  endfunction

  // period counter running on the register clock clk
  smon_period_counter u_counter (
    .clk          (clk),
    .nrst         (nrst),
    .period       (q.period),
    .period_count (period_count)
  );

  // handshake outputs straight from the holding flags
  always_comb begin
    axi_rsp.awready = !q.aw_full && !q.bvalid;
    axi_rsp.wready  = !q.w_full && !q.bvalid;
    axi_rsp.bvalid  = q.bvalid;
    axi_rsp.bresp   = q.bresp;
    axi_rsp.arready = !q.rvalid;
    axi_rsp.rvalid  = q.rvalid;
    axi_rsp.rdata   = {24'h000000, q.rbyte};
    axi_rsp.rresp   = q.rresp;
  end

  assign commit = q.aw_full && q.w_full && !q.bvalid;
  assign rd_idx = axi_req.araddr[SMON_ADDR_W-1:SMON_IDX_LSB];

  // next state: bus channels, register writes, result transfer
  always_comb begin
    d = q;
    // take write address
    if (axi_req.awvalid && axi_rsp.awready) begin
      d.aw_full = 1'b1;
      d.aw_idx  = axi_req.awaddr[SMON_ADDR_W-1:SMON_IDX_LSB];
    end
    // take write data, only the low lane matters
    if (axi_req.wvalid && axi_rsp.wready) begin
      d.w_full = 1'b1;
      d.wbyte  = axi_req.wdata[7:0];
      d.wlane  = axi_req.wstrb[0];
    end
    // write response taken
    if (q.bvalid && axi_req.bready) begin
      d.bvalid = 1'b0;
    end
    // transfer measurement while the strobe stands
    if (q.update) begin
      d.update = 1'b0;
      if (q.peak_sel) begin
        // peak magnitude over seven zero bits
        d.result = {peak_abs, {SMON_PEAK_LSB{1'b0}}};
      end else begin
        // no other source in this block, report zero
        d.result = '0;
      end
      d.pcount = period_count;
    end
    // perform the write once address and data are both in
    if (commit) begin
      d.aw_full = 1'b0;
      d.w_full  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = idx_hit(q.aw_idx) ? SMON_RESP_OKAY : SMON_RESP_SLVERR;
      if (q.wlane) begin
        unique case (q.aw_idx)
          // bit 0 of the period is fixed at zero
          SMON_IDX_PER_LO:  d.period[7:0]   = {q.wbyte[7:1], 1'b0};
          SMON_IDX_PER_MID: d.period[15:8]  = q.wbyte;
          SMON_IDX_PER_HI:  d.period[23:16] = q.wbyte;
          SMON_IDX_CTL: begin
            d.peak_sel = q.wbyte[SMON_CTL_PEAK_BIT];
            // writing zero to the strobe does nothing
            if (q.wbyte[SMON_CTL_UPDATE_BIT]) begin
              d.update = 1'b1;
            end
          end
          default: begin
            // read-only or unmapped, nothing stored
          end
        endcase
      end
    end
    // read data taken
    if (q.rvalid && axi_req.rready) begin
      d.rvalid = 1'b0;
    end
    // take a read request and answer next cycle
    if (axi_req.arvalid && axi_rsp.arready) begin
      d.rvalid = 1'b1;
      d.rbyte  = read_byte(rd_idx, q);
      d.rresp  = idx_hit(rd_idx) ? SMON_RESP_OKAY : SMON_RESP_SLVERR;
    end
  end

  // register the whole state, synchronous reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= SMON_ST_RST;
    end else begin
      q <= d;
    end
  end

  assign peak_enable    = q.peak_sel;
  assign monitor_period = q.period;

  // strobe moves peak into the result one cycle later
  chk_update_xfer: assert property (@(posedge clk) disable iff (!nrst)
    q.update && q.peak_sel |=> d.result == q.result &&
      q.result[SMON_RES_W-1:SMON_PEAK_LSB] == $past(peak_abs))
    else $error("peak not transferred on update");

  // period count captured on update
  chk_pcount_xfer: assert property (@(posedge clk) disable iff (!nrst)
    q.update |=> q.pcount == $past(period_count))
    else $error("period count not transferred on update");

  // strobe stands exactly one cycle
  chk_update_clear: assert property (@(posedge clk) disable iff (!nrst)
    $rose(q.update) |=> !q.update)
    else $error("update bit did not clear itself");

  // strobe only follows a committed control write
  chk_update_cause: assert property (@(posedge clk) disable iff (!nrst)
    $rose(q.update) |-> $past(commit) && $past(q.aw_idx) == SMON_IDX_CTL)
    else $error("update bit rose without a control write");

  // without peak source the result reads zero
  chk_source_zero: assert property (@(posedge clk) disable iff (!nrst)
    q.update && !q.peak_sel |=> q.result == '0)
    else $error("result not zero without peak source");

  // low result bits are zero with peak selected
  chk_low_zero: assert property (@(posedge clk) disable iff (!nrst)
    q.update && q.peak_sel |=> q.result[SMON_PEAK_LSB-1:0] == '0)
    else $error("low result bits not zero");

  // period bit 0 stays zero, reset value after release
  chk_period_lsb: assert property (@(posedge clk) disable iff (!nrst)
    $rose(nrst) |-> q.period == SMON_PER_RST ##1 q.period[0] == 1'b0)
    else $error("period reset value or bit 0 wrong");

  // a committed write answers next cycle
  chk_write_resp: assert property (@(posedge clk) disable iff (!nrst)
    commit |=> q.bvalid && !q.aw_full && !q.w_full)
    else $error("write response missing after commit");

  // period bit 0 never holds a one, whatever was written
  chk_period_bit0: assert property (@(posedge clk) disable iff (!nrst)
    q.period[0] == 1'b0)
    else $error("period bit 0 not zero");

  // results change only through the update strobe
  chk_result_hold: assert property (@(posedge clk) disable iff (!nrst)
    !q.update |=> $stable(q.result) && $stable(q.pcount))
    else $error("result registers changed without update");

  // a control write stores the peak selection bit
  chk_ctl_write: assert property (@(posedge clk) disable iff (!nrst)
    commit && q.wlane && (q.aw_idx == SMON_IDX_CTL) |=>
      q.peak_sel == $past(q.wbyte[SMON_CTL_PEAK_BIT]))
    else $error("peak selection not stored on control write");

  // strobe rises together with the write response
  chk_update_resp: assert property (@(posedge clk) disable iff (!nrst)
    $rose(q.update) |-> q.bvalid)
    else $error("update bit rose without a write response");

  // an accepted read answers in the next cycle
  chk_read_resp: assert property (@(posedge clk) disable iff (!nrst)
    axi_req.arvalid && axi_rsp.arready |=> q.rvalid)
    else $error("read response missing after request");

endmodule

// File: rtl/smon_pkg.sv
// constants, carrier structs and state types of the signal monitor registers
package smon_pkg;

  // widths of the bus and of the monitor quantities
  localparam int SMON_ADDR_W = 12;            // byte address width on the bus
  localparam int SMON_DATA_W = 32;            // bus data width
  localparam int SMON_IDX_W  = 10;            // register index width
  localparam int SMON_IDX_LSB = 2;            // index starts above the byte bits
  localparam int SMON_BYTE_W = 8;             // every register is one byte
  localparam int SMON_PER_W  = 24;            // monitor period width
  localparam int SMON_RES_W  = 20;            // monitor result width
  localparam int SMON_PEAK_W = 13;            // peak magnitude width
  localparam int SMON_PEAK_LSB = 7;           // peak sits above this many zeros
  localparam int SMON_PCNT_W = 8;             // period count result width

  // register indexes; byte address is four times the index
  localparam logic [SMON_IDX_W-1:0] SMON_IDX_PER_LO  = 10'h271;
  localparam logic [SMON_IDX_W-1:0] SMON_IDX_PER_MID = 10'h272;
  localparam logic [SMON_IDX_W-1:0] SMON_IDX_PER_HI  = 10'h273;
  localparam logic [SMON_IDX_W-1:0] SMON_IDX_CTL     = 10'h274;
  localparam logic [SMON_IDX_W-1:0] SMON_IDX_RES0    = 10'h275;
  localparam logic [SMON_IDX_W-1:0] SMON_IDX_RES1    = 10'h276;
  localparam logic [SMON_IDX_W-1:0] SMON_IDX_RES2    = 10'h277;
  localparam logic [SMON_IDX_W-1:0] SMON_IDX_PCNT    = 10'h278;

  // control register fields
  localparam int SMON_CTL_PEAK_BIT   = 0;     // peak detector selected
  localparam int SMON_CTL_UPDATE_BIT = 4;     // self-clearing update strobe

  // reset values
  localparam logic [SMON_PER_W-1:0] SMON_PER_RST = 24'h000080;

  // bus response codes
  localparam logic [1:0] SMON_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SMON_RESP_SLVERR = 2'h2;

  // master to slave signals of the register bus
  typedef struct packed {
    logic                   awvalid;
    logic [SMON_ADDR_W-1:0] awaddr;
    logic                   wvalid;
    logic [SMON_DATA_W-1:0] wdata;
    logic [3:0]             wstrb;
    logic                   bready;
    logic                   arvalid;
    logic [SMON_ADDR_W-1:0] araddr;
    logic                   rready;
  } smon_axi_req_t;

  // slave to master signals of the register bus
  typedef struct packed {
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [SMON_DATA_W-1:0] rdata;
    logic [1:0]             rresp;
  } smon_axi_rsp_t;

  // whole state of the register block
  typedef struct packed {
    logic [SMON_PER_W-1:0]  period;   // monitor period, bit 0 held at zero
    logic                   peak_sel; // peak detector is the result source
    logic                   update;   // update strobe, clears itself
    logic [SMON_RES_W-1:0]  result;   // monitor result
    logic [SMON_PCNT_W-1:0] pcount;   // period count result
    logic                   aw_full;  // write address held
    logic [SMON_IDX_W-1:0]  aw_idx;   // held write index
    logic                   w_full;   // write data held
    logic [SMON_BYTE_W-1:0] wbyte;    // held low write byte
    logic                   wlane;    // low byte lane enabled
    logic                   bvalid;   // write response pending
    logic [1:0]             bresp;    // write response code
    logic                   rvalid;   // read data pending
    logic [SMON_BYTE_W-1:0] rbyte;    // read data byte
    logic [1:0]             rresp;    // read response code
  } smon_state_t;

  localparam smon_state_t SMON_ST_RST = '{
    period: SMON_PER_RST, peak_sel: 1'b0, update: 1'b0, result: '0,
    pcount: '0, aw_full: 1'b0, aw_idx: '0, w_full: 1'b0, wbyte: '0,
    wlane: 1'b0, bvalid: 1'b0, bresp: SMON_RESP_OKAY, rvalid: 1'b0,
    rbyte: '0, rresp: SMON_RESP_OKAY};

  // state of the period counter
  typedef struct packed {
    logic [SMON_PER_W-1:0]  cnt;      // cycles into the current period
    logic [SMON_PCNT_W-1:0] periods;  // completed periods, wrapping
  } smon_cnt_state_t;

  localparam smon_cnt_state_t SMON_CNT_RST = '{cnt: '0, periods: '0};

endpackage

// File: rtl/smon_period_counter.sv
// period counter of the signal monitor: counts clock cycles per period
`timescale 1ns/1ps
module smon_period_counter
  import smon_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic [SMON_PER_W-1:0]  period,
  output logic [SMON_PCNT_W-1:0]      period_count
);

  smon_cnt_state_t q;       // registered state
  smon_cnt_state_t d;       // next state
  logic [SMON_PER_W-1:0] cnt_plus; // cycle count after this cycle

  // advance the cycle count, wrap at the period and count periods
  always_comb begin
    d = q;
    cnt_plus = q.cnt + 24'h000001;
    if (cnt_plus >= period) begin
      // period over, a zero period ends every cycle
      d.cnt = '0;
      d.periods = q.periods + 8'h01;
    end else begin
      d.cnt = cnt_plus;
    end
  end

  // register the state, synchronous reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= SMON_CNT_RST;
    end else begin
      q <= d;
    end
  end

  assign period_count = q.periods;

  // count never passes the programmed period
  chk_cnt_bound: assert property (@(posedge clk) disable iff (!nrst)
    (period != '0) && $stable(period) |=> (q.cnt < $past(period)))
    else $error("period counter ran past the period");

endmodule

// File: verif/smon_tb.sv
// self-checking testbench of the signal monitor result registers
`timescale 1ns/1ps
module testbench;
  import smon_pkg::*;
  // one table row: write address and byte, expected readback
  typedef struct packed {
    logic [11:0] a;
    logic [7:0]  w;
    logic [7:0]  r;
  } smon_tb_row_t;
  logic                    clk;            // bench clock
  logic                    nrst;           // active low reset
  smon_axi_req_t           req;            // bus requests
  smon_axi_rsp_t           rsp;            // bus answers
  logic [SMON_PEAK_W-1:0]  peak_abs;       // peak detector value
  logic                    peak_enable;    // peak source selected
  logic [SMON_PER_W-1:0]   monitor_period; // period register
  int                      n_fail;         // mismatches
  int                      n_tests;        // comparisons
  logic [SMON_RES_W-1:0]   exp_res;        // expected monitor result
  smon_tb_row_t rows [6] = '{'{12'h9c4, 8'hff, 8'hfe},
    '{12'h9c8, 8'h5a, 8'h5a}, '{12'h9cc, 8'ha5, 8'ha5},
    '{12'h9d0, 8'h01, 8'h01}, '{12'h9d4, 8'hff, 8'h00},
    '{12'h9e0, 8'h33, 8'h00}};
  logic [12:0] pk [3] = '{13'h1abc, 13'h0001, 13'h1fff}; // peak values
  logic [7:0]  cv [3] = '{8'h11, 8'h11, 8'h10};          // control bytes

  smon_result_regs u_smon_result_regs (
    .clk            (clk),
    .nrst           (nrst),
    .axi_req        (req),
    .axi_rsp        (rsp),
    .peak_abs       (peak_abs),
    .peak_enable    (peak_enable),
    .monitor_period (monitor_period)
  );

  // free running clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // compare of data values
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // compare of response codes
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one bus write; address and data offered together, each held until taken
  task automatic wrc(input logic [11:0] a, input logic [7:0] d,
                     input logic [1:0] er);
    logic ta;
    logic tw;
    @(posedge clk);
    req.awaddr  <= a;
    req.awvalid <= 1'b1;
    req.wdata   <= {24'h0, d};
    req.wstrb   <= 4'h1;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    do begin
      @(negedge clk);
      ta = req.awvalid && rsp.awready;
      tw = req.wvalid && rsp.wready;
      @(posedge clk);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
    end while ((req.awvalid && !ta) || (req.wvalid && !tw));
    do @(negedge clk); while (!rsp.bvalid);
    chk_resp(rsp.bresp, er);
    @(posedge clk);
    req.bready <= 1'b0;
  endtask

  // one bus read with check of byte and response
  task automatic rdc(input logic [11:0] a, input logic [7:0] ed,
                     input logic [1:0] er);
    @(posedge clk);
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    do @(negedge clk); while (!rsp.arready);
    @(posedge clk);
    req.arvalid <= 1'b0;
    do @(negedge clk); while (!rsp.rvalid);
    chk_val(rsp.rdata, {24'h0, ed});
    chk_resp(rsp.rresp, er);
    @(posedge clk);
    req.rready <= 1'b0;
  endtask

  // counts, verdict and end of run
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done;
  end

  // main sequence
  initial begin
    nrst = 1'b0;
    req = '0;
    peak_abs = '0;
    n_fail = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    // reset values of the period and control registers
    rdc(12'h9c4, 8'h80, SMON_RESP_OKAY);
    rdc(12'h9c8, 8'h00, SMON_RESP_OKAY);
    rdc(12'h9cc, 8'h00, SMON_RESP_OKAY);
    rdc(12'h9d0, 8'h00, SMON_RESP_OKAY);
    chk_val(32'(monitor_period), 32'h80);
    $display("reset test done");
    // table of ordinary writes and readbacks
    foreach (rows[i]) begin
      wrc(rows[i].a, rows[i].w, SMON_RESP_OKAY);
      rdc(rows[i].a, rows[i].r, SMON_RESP_OKAY);
    end
    chk_val(32'(monitor_period), 32'ha55afe);
    chk_val(32'(peak_enable), 32'h1);
    $display("table test done");
    // update strobes with and without the peak source, boundary values
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      peak_abs <= pk[i];
      exp_res = cv[i][0] ? {pk[i], 7'h00} : '0;
      wrc(12'h9d0, cv[i], SMON_RESP_OKAY);
      rdc(12'h9d4, exp_res[7:0], SMON_RESP_OKAY);
      rdc(12'h9d8, exp_res[15:8], SMON_RESP_OKAY);
      rdc(12'h9dc, {4'h0, exp_res[19:16]}, SMON_RESP_OKAY);
      rdc(12'h9d0, cv[i] & 8'h01, SMON_RESP_OKAY);
      chk_val(32'(peak_enable), 32'(cv[i][0]));
    end
    rdc(12'h9e0, 8'h00, SMON_RESP_OKAY);
    $display("update test done");
    // unmapped places refused without effect
    wrc(12'h9e4, 8'h5a, SMON_RESP_SLVERR);
    rdc(12'h9c0, 8'h00, SMON_RESP_SLVERR);
    chk_val(32'(monitor_period), 32'ha55afe);
    $display("unmapped test done");
    // second reset in mid-run
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk_val(32'(monitor_period), 32'h80);
    chk_val(32'(peak_enable), 32'h0);
    $display("second reset test done");
    // 303 cycles after release at the reset period of 128: two periods
    repeat (300) @(posedge clk);
    wrc(12'h9d0, 8'h10, SMON_RESP_OKAY);
    rdc(12'h9e0, 8'h02, SMON_RESP_OKAY);
    $display("period count test done");
    test_done;
  end
endmodule
